// [shared/byte_exec_map.svh]
// opcode prefixes, field positions, reset values and phase timing for the byte executor
`ifndef BYTE_EXEC_MAP_SVH
`define BYTE_EXEC_MAP_SVH

// upper-byte opcode prefixes
`define OPC_BANK_LITERAL_LOAD  8'h01
`define OPC_ACC_LITERAL_LOAD   8'h0e
`define OPC_LITERAL_MULTIPLY   8'h0d
// acc_store_to_file: upper seven bits 0110 111, bit 8 is the access selector
`define OPC_ACC_STORE_TO_FILE  7'h37
// mem_to_mem_move word prefixes (top nibble)
`define OPC_MOVE_SRC_WORD      4'hc
`define OPC_MOVE_DST_WORD      4'hf

// field positions inside an instruction word
`define FLD_OPC_HI             15
`define FLD_OPC_LO             8
`define FLD_ACCESS_SEL         8
`define FLD_NIB_HI             15
`define FLD_NIB_LO             12
`define FLD_ADDR12_HI          11
`define FLD_LIT_HI             7

// access bank split: low offsets map to bank 0, the rest to the top bank
`define ACCESS_SPLIT           8'h80
`define ACCESS_LOW_BANK        4'h0
`define ACCESS_HIGH_BANK       4'hf

// reset values
`define RST_ACC                8'h00
`define RST_BANK_SEL           8'h00
`define RST_PRODUCT            8'h00

// clocks per instruction cycle (four phases)
`define PHASES_PER_CYCLE       4

`endif

// [shared/byte_exec_pkg.sv]
// types shared by the byte executor and its phase sequencer
package byte_exec_pkg;

    // one instruction cycle, one clock per phase
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } phase_t;

    // decoded operation held for the current instruction cycle
    typedef enum logic [2:0] {
        OP_NONE,
        OP_BANK_LOAD,
        OP_ACC_LOAD,
        OP_ACC_STORE,
        OP_MULTIPLY,
        OP_MOVE_SRC,
        OP_MOVE_DST
    } op_t;

    // sequencing of the two-word move
    typedef enum logic [1:0] {
        MV_IDLE,
        MV_WAIT_DST,
        MV_HAVE_DST
    } move_state_t;

    // data memory port bundle
    typedef struct packed {
        logic        rdEn;
        logic [11:0] rdAddr;
        logic        wrEn;
        logic [11:0] wrAddr;
        logic [7:0]  wrData;
    } mem_port_t;

    // architectural registers owned by this slice
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] bankSel;
        logic [7:0] productHigh;
        logic [7:0] productLow;
    } arch_regs_t;

endpackage : byte_exec_pkg

// [design/quad_phase_seq.sv]
// four-phase sequencer: one clock per phase of the instruction cycle
module quad_phase_seq (
    input  wire logic                  clk,
    input  wire logic                  rst,
    output byte_exec_pkg::phase_t      phase
);

    typedef struct packed {
        byte_exec_pkg::phase_t phase;
    } seq_state_t;

    seq_state_t state_r;
    seq_state_t state_nxt;

    // free-running decode, read, process, write rotation
    always_comb begin
        state_nxt = state_r;
        unique case (state_r.phase)
            byte_exec_pkg::PH_DECODE:  state_nxt.phase = byte_exec_pkg::PH_READ;
            byte_exec_pkg::PH_READ:    state_nxt.phase = byte_exec_pkg::PH_PROCESS;
            byte_exec_pkg::PH_PROCESS: state_nxt.phase = byte_exec_pkg::PH_WRITE;
            byte_exec_pkg::PH_WRITE:   state_nxt.phase = byte_exec_pkg::PH_DECODE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r.phase <= byte_exec_pkg::PH_DECODE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign phase = state_r.phase;

endmodule : quad_phase_seq

// [design/byte_move_multiply_exec.sv]
// executor for the move, literal load, store and literal multiply instruction slice
`include "byte_exec_map.svh"

// the core feeds one word per decode phase; results appear in the write phase of
// the same instruction cycle, memory writes as one-clock strobes in that phase
module byte_move_multiply_exec (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [15:0]                instrWord,
    input  wire logic                       instrValid,
    input  wire logic [7:0]                 memRdData,
    output byte_exec_pkg::phase_t           phase,
    output logic                            instrTaken,
    output logic                            moveWaiting,
    output logic                            statusWrEn,
    output byte_exec_pkg::arch_regs_t       regs,
    output byte_exec_pkg::mem_port_t        mem
);

    // whole module state in one record
    // moveWait repeats a state decode so that its port leaves a flip-flop directly
    typedef struct packed {
        byte_exec_pkg::op_t         op;
        byte_exec_pkg::move_state_t mvState;
        logic [15:0]                word;
        logic [7:0]                 moveData;
        logic                       taken;
        logic                       moveWait;
        logic                       statusWr;
        byte_exec_pkg::arch_regs_t  regs;
        byte_exec_pkg::mem_port_t   mem;
    } exec_state_t;

    exec_state_t state_r;
    exec_state_t state_nxt;

    // decoded in decode phase from the incoming word
    byte_exec_pkg::op_t decodedOp;
    logic [15:0]        product;

    // phase rotation lives in its own small module; the phase port is its flip-flop
    quad_phase_seq phaseSeq (
        .clk   (clk),
        .rst   (rst),
        .phase (phase)
    );

    // decode priority: a move destination word is only meaningful while a move waits;
    // outside a move a lone destination word falls through and decodes as nothing,
    // and inside a move any other word abandons it and still executes normally
    // classify one instruction word; move second word only matters mid-move
    function automatic byte_exec_pkg::op_t decodeWord(input logic [15:0] w,
                                                      input logic        expectDst);
        byte_exec_pkg::op_t o;
        o = byte_exec_pkg::OP_NONE;
        if (expectDst && w[`FLD_NIB_HI:`FLD_NIB_LO] == `OPC_MOVE_DST_WORD) begin
            o = byte_exec_pkg::OP_MOVE_DST;
        end else if (w[`FLD_NIB_HI:`FLD_NIB_LO] == `OPC_MOVE_SRC_WORD) begin
            o = byte_exec_pkg::OP_MOVE_SRC;
        end else if (w[`FLD_OPC_HI:`FLD_OPC_LO] == `OPC_BANK_LITERAL_LOAD) begin
            o = byte_exec_pkg::OP_BANK_LOAD;
        end else if (w[`FLD_OPC_HI:`FLD_OPC_LO] == `OPC_ACC_LITERAL_LOAD) begin
            o = byte_exec_pkg::OP_ACC_LOAD;
        end else if (w[`FLD_OPC_HI:`FLD_OPC_LO] == `OPC_LITERAL_MULTIPLY) begin
            o = byte_exec_pkg::OP_MULTIPLY;
        end else if (w[`FLD_OPC_HI:`FLD_ACCESS_SEL + 1] == `OPC_ACC_STORE_TO_FILE) begin
            o = byte_exec_pkg::OP_ACC_STORE;
        end
        return o;
    endfunction : decodeWord

    // access bank: lower half of the page maps to the bottom bank, upper half to the
    // top bank, so common registers are reachable without touching bank select
    // 8-bit file offset plus access bit to a 12-bit data address
    function automatic logic [11:0] bankedAddr(input logic [7:0] f,
                                               input logic       accessSel,
                                               input logic [7:0] bank);
        logic [11:0] a;
        if (accessSel) begin
            a = {bank[3:0], f};
        end else if (f < `ACCESS_SPLIT) begin
            a = {`ACCESS_LOW_BANK, f};
        end else begin
            a = {`ACCESS_HIGH_BANK, f};
        end
        return a;
    endfunction : bankedAddr

    assign decodedOp = decodeWord(instrWord, state_r.mvState != byte_exec_pkg::MV_IDLE);
    // the multiplier serves only this instruction, so a plain 8x8 array is cheapest;
    // it sees the accumulator as it stands at the process edge, which already holds
    // any load made by the instruction just before
    // 8x8 unsigned fits exactly in 16 bits, no carry or overflow possible
    assign product   = 16'(state_r.regs.acc) * 16'(state_r.word[`FLD_LIT_HI:0]);

    // instruction cycle timeline, one clock per phase:
    //   decode edge  - word and its decoded operation are latched, move source read issued
    //   read edge    - only the read strobe and taken pulse drop; read data from the data memory settles meanwhile
    //   process edge - results registered, so they stand through the whole write phase
    //   write edge   - next decode begins, results stay until the next writer
    // registering on the process edge rather than the write edge costs no throughput
    // and lets the core sample results in the write phase it expects
    // limitation: memory read data must be valid by the process edge, one clock after
    // the read strobe; a slower memory would need the read phase stretched
    // a move stretched by a missing second word simply burns whole idle cycles; the
    // source byte waits in moveData, so no second read is ever needed
    // an abandoned move leaves its captured byte behind; a later move always
    // overwrites it in its own process phase before any destination can use it
    // phase-stepped execution: capture in decode, read, process, write
    always_comb begin
        state_nxt          = state_r;
        state_nxt.taken    = 1'b0;
        state_nxt.mem.rdEn = 1'b0;
        state_nxt.mem.wrEn = 1'b0;
        // no instruction in this slice ever touches status flags
        state_nxt.statusWr = 1'b0;
        unique case (phase)
            byte_exec_pkg::PH_DECODE: begin
                state_nxt.op = byte_exec_pkg::OP_NONE;
                if (instrValid) begin
                    state_nxt.taken = 1'b1;
                    state_nxt.word  = instrWord;
                    state_nxt.op    = decodedOp;
                    if (decodedOp == byte_exec_pkg::OP_MOVE_SRC) begin
                        // source read issued for the read phase
                        state_nxt.mem.rdEn   = 1'b1;
                        state_nxt.mem.rdAddr = instrWord[`FLD_ADDR12_HI:0];
                        state_nxt.mvState    = byte_exec_pkg::MV_WAIT_DST;
                    end else if (decodedOp == byte_exec_pkg::OP_MOVE_DST) begin
                        // second word: no dummy read, write comes in its last phase
                        state_nxt.mvState = byte_exec_pkg::MV_HAVE_DST;
                    end else begin
                        // anything but a destination word abandons a pending move
                        state_nxt.mvState = byte_exec_pkg::MV_IDLE;
                    end
                end
                // no word offered: a pending move stretches by whole cycles
            end
            byte_exec_pkg::PH_READ: begin
                // move source data arrives one clock after its read strobe
            end
            byte_exec_pkg::PH_PROCESS: begin
                unique case (state_r.op)
                    byte_exec_pkg::OP_MOVE_SRC: begin
                        state_nxt.moveData = memRdData;
                    end
                    byte_exec_pkg::OP_MOVE_DST: begin
                        state_nxt.mem.wrEn   = 1'b1;
                        state_nxt.mem.wrAddr = state_r.word[`FLD_ADDR12_HI:0];
                        state_nxt.mem.wrData = state_r.moveData;
                        state_nxt.mvState    = byte_exec_pkg::MV_IDLE;
                    end
                    byte_exec_pkg::OP_BANK_LOAD: begin
                        state_nxt.regs.bankSel = state_r.word[`FLD_LIT_HI:0];
                    end
                    byte_exec_pkg::OP_ACC_LOAD: begin
                        state_nxt.regs.acc = state_r.word[`FLD_LIT_HI:0];
                    end
                    byte_exec_pkg::OP_ACC_STORE: begin
                        state_nxt.mem.wrEn   = 1'b1;
                        state_nxt.mem.wrAddr = bankedAddr(state_r.word[`FLD_LIT_HI:0],
                                                          state_r.word[`FLD_ACCESS_SEL],
                                                          state_r.regs.bankSel);
                        state_nxt.mem.wrData = state_r.regs.acc;
                    end
                    byte_exec_pkg::OP_MULTIPLY: begin
                        // accumulator deliberately not assigned here
                        state_nxt.regs.productHigh = product[15:8];
                        state_nxt.regs.productLow  = product[7:0];
                    end
                    byte_exec_pkg::OP_NONE: begin
                    end
                    default: begin
                        // unused operation code: nothing to do
                    end
                endcase
            end
            byte_exec_pkg::PH_WRITE: begin
                // results are visible throughout the write phase
            end
        endcase
        // registered copy so the waiting flag comes from a flip-flop
        state_nxt.moveWait = (state_nxt.mvState == byte_exec_pkg::MV_WAIT_DST);
    end

    // asynchronous reset clears every field to a constant; the phase sequencer resets to
    // decode on the same event, so the first edge after release is always a decode edge

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r.op               <= byte_exec_pkg::OP_NONE;
            state_r.mvState          <= byte_exec_pkg::MV_IDLE;
            state_r.word             <= 16'h0000;
            state_r.moveData         <= 8'h00;
            state_r.taken            <= 1'b0;
            state_r.moveWait         <= 1'b0;
            state_r.statusWr         <= 1'b0;
            state_r.regs.acc         <= `RST_ACC;
            state_r.regs.bankSel     <= `RST_BANK_SEL;
            state_r.regs.productHigh <= `RST_PRODUCT;
            state_r.regs.productLow  <= `RST_PRODUCT;
            state_r.mem              <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state record; no logic between flip-flop and port
    assign instrTaken  = state_r.taken;
    assign moveWaiting = state_r.moveWait;
    assign statusWrEn  = state_r.statusWr;
    assign regs        = state_r.regs;
    assign mem         = state_r.mem;

endmodule : byte_move_multiply_exec

// [tb/byte_move_multiply_exec_checker.sv]
// port-level assertions for the byte executor slice
`include "byte_exec_map.svh"
module byte_move_multiply_exec_checker (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic [15:0]               instrWord,
    input wire logic                      instrValid,
    input wire logic [7:0]                memRdData,
    input wire byte_exec_pkg::phase_t     phase,
    input wire logic                      instrTaken,
    input wire logic                      moveWaiting,
    input wire logic                      statusWrEn,
    input wire byte_exec_pkg::arch_regs_t regs,
    input wire byte_exec_pkg::mem_port_t  mem
);
    // a word counts only on a decode edge
    logic take;
    assign take = phase == byte_exec_pkg::PH_DECODE && instrValid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_take; take |=> instrTaken ##1 !instrTaken; endproperty
    a_take: assert property (p_take) else $error("word not acknowledged");
    property p_accLoad; take && instrWord[15:8] == `OPC_ACC_LITERAL_LOAD
        |=> ##2 regs.acc == $past(instrWord[7:0], 3); endproperty
    a_accLoad: assert property (p_accLoad) else $error("acc load wrong");
    property p_bankLoad; take && instrWord[15:8] == `OPC_BANK_LITERAL_LOAD
        |=> ##2 regs.bankSel == $past(instrWord[7:0], 3); endproperty
    a_bankLoad: assert property (p_bankLoad) else $error("bank load wrong");
    property p_mul; take && instrWord[15:8] == `OPC_LITERAL_MULTIPLY |=> ##2
        {regs.productHigh, regs.productLow} ==
        16'($past(regs.acc, 3)) * 16'($past(instrWord[7:0], 3)); endproperty
    a_mul: assert property (p_mul) else $error("product wrong");
    property p_mulAcc; take && instrWord[15:8] == `OPC_LITERAL_MULTIPLY
        |=> $stable(regs.acc) [*3]; endproperty
    a_mulAcc: assert property (p_mulAcc) else $error("multiply touched acc");
    property p_flags; statusWrEn == 1'b0; endproperty
    a_flags: assert property (p_flags) else $error("flag write seen");
    // store: data and offset, both from the take edge
    property p_store; take && instrWord[15:9] == `OPC_ACC_STORE_TO_FILE |=> ##2 mem.wrEn
        && mem.wrData == $past(regs.acc, 3) && mem.wrAddr[7:0] == $past(instrWord[7:0], 3);
    endproperty
    a_store: assert property (p_store) else $error("store write wrong");
    property p_access; take && instrWord[15:9] == `OPC_ACC_STORE_TO_FILE |=> ##2
        mem.wrAddr[11:8] == ($past(instrWord[8], 3) ? $past(regs.bankSel[3:0], 3)
        : {4{$past(instrWord[7], 3)}}); endproperty
    a_access: assert property (p_access) else $error("store bank wrong");
    property p_src; take && instrWord[15:12] == `OPC_MOVE_SRC_WORD |=> mem.rdEn
        && moveWaiting && mem.rdAddr == $past(instrWord[11:0]) ##2 !mem.wrEn; endproperty
    a_src: assert property (p_src) else $error("move source read wrong");
    property p_dst; take && moveWaiting && instrWord[15:12] == `OPC_MOVE_DST_WORD
        |=> ##2 mem.wrEn && mem.wrAddr == $past(instrWord[11:0], 3); endproperty
    a_dst: assert property (p_dst) else $error("move dest write wrong");
    property p_wrPhase; mem.wrEn |-> phase == byte_exec_pkg::PH_WRITE; endproperty
    a_wrPhase: assert property (p_wrPhase) else $error("write outside phase");
    property p_phase; phase == byte_exec_pkg::PH_DECODE |=> phase == byte_exec_pkg::PH_READ
        ##1 phase == byte_exec_pkg::PH_PROCESS ##1 phase == byte_exec_pkg::PH_WRITE
        ##1 phase == byte_exec_pkg::PH_DECODE; endproperty
    a_phase: assert property (p_phase) else $error("phase rotation wrong");
endmodule : byte_move_multiply_exec_checker

// [tb/byte_move_multiply_exec_test.sv]
// self-checking bench for the byte executor slice
`include "byte_exec_map.svh"
module byte_move_multiply_exec_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        byte_exec_pkg::arch_regs_t regs;
        logic                      wrEn;
        logic [11:0]               wrAddr;
        logic [7:0]                wrData;
    } note_t;

    logic                      clk, rst, instrValid, instrTaken, moveWaiting, statusWrEn;
    logic [15:0]               instrWord;
    logic [7:0]                memRdData;
    byte_exec_pkg::phase_t     phase;
    byte_exec_pkg::arch_regs_t regs, expRegs;
    byte_exec_pkg::mem_port_t  mem;
    note_t                     notes[$];
    logic [11:0]               pendSrc;
    logic                      pend;
    int                        errTotal, checksDone, cycles;

    byte_move_multiply_exec dut (.clk(clk), .rst(rst), .instrWord(instrWord),
        .instrValid(instrValid), .memRdData(memRdData), .phase(phase),
        .instrTaken(instrTaken), .moveWaiting(moveWaiting), .statusWrEn(statusWrEn),
        .regs(regs), .mem(mem));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // memory answers in process phase only; junk otherwise so stale data is never trusted
    always @(negedge clk) begin
        memRdData <= (phase === byte_exec_pkg::PH_PROCESS) ? mem.rdAddr[7:0] ^ 8'h5a
                                                           : 8'($urandom);
    end

    // hang guard, generous against roughly 440 clocks of traffic
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errTotal++;
            reportAndStop();
        end
    end

    task automatic reportAndStop();
        if (errTotal == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : reportAndStop

    task automatic cmpRegs(input byte_exec_pkg::arch_regs_t e, input byte_exec_pkg::arch_regs_t s);
        checksDone++;
        if (s !== e) begin
            errTotal++;
            $display("ERROR regs expected %h seen %h", e, s);
        end
    endtask : cmpRegs

    task automatic cmpWrite(input note_t e, input byte_exec_pkg::mem_port_t s);
        checksDone++;
        if (s.wrEn !== e.wrEn || (e.wrEn && {s.wrAddr, s.wrData} !== {e.wrAddr, e.wrData})) begin
            errTotal++;
            $display("ERROR memWrite expected %h seen %h", {e.wrEn, e.wrAddr, e.wrData},
                     {s.wrEn, s.wrAddr, s.wrData});
        end
    endtask : cmpWrite

    // results land in write phase; oldest note belongs to this cycle
    always @(negedge clk) begin
        if (rst === 1'b0 && phase === byte_exec_pkg::PH_WRITE && notes.size() > 0) begin
            note_t n;
            n = notes.pop_front();
            cmpRegs(n.regs, regs);
            cmpWrite(n, mem);
        end
    end

    // offer one word at the next decode phase and note what it should do
    task automatic issue(input logic [15:0] w);
        note_t n;
        n = '0;
        if (w[15:8] == `OPC_BANK_LITERAL_LOAD) expRegs.bankSel = w[7:0];
        if (w[15:8] == `OPC_ACC_LITERAL_LOAD) expRegs.acc = w[7:0];
        if (w[15:8] == `OPC_LITERAL_MULTIPLY)
            {expRegs.productHigh, expRegs.productLow} = 16'(expRegs.acc) * 16'(w[7:0]);
        if (w[15:9] == `OPC_ACC_STORE_TO_FILE) begin
            n.wrEn = 1'b1;
            n.wrData = expRegs.acc;
            n.wrAddr = {w[8] ? expRegs.bankSel[3:0] : {4{w[7]}}, w[7:0]};
        end
        if (w[15:12] == `OPC_MOVE_DST_WORD && pend) begin
            n.wrEn = 1'b1;
            n.wrAddr = w[11:0];
            n.wrData = pendSrc[7:0] ^ 8'h5a;
        end
        pend = w[15:12] == `OPC_MOVE_SRC_WORD;
        pendSrc = w[11:0];
        n.regs = expRegs;
        while (phase !== byte_exec_pkg::PH_DECODE) @(negedge clk);
        instrWord = w;
        instrValid = 1'b1;
        notes.push_back(n);
        @(negedge clk);
        instrValid = 1'b0;
        instrWord = 16'($urandom);
    endtask : issue

    // one instruction cycle with nothing offered
    task automatic idle();
        while (phase !== byte_exec_pkg::PH_DECODE) @(negedge clk);
        @(negedge clk);
    endtask : idle

    initial begin
        logic [7:0] k;
        rst = 1'b1;
        instrValid = 1'b0;
        instrWord = 16'h0000;
        expRegs = '0;
        pend = 1'b0;
        pendSrc = 12'h000;
        void'($urandom(35106));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        // corners: largest product, zero product, store banking on both halves
        issue({8'h0e, 8'hff});
        issue({8'h0d, 8'hff});
        issue({8'h0d, 8'h00});
        issue({8'h01, 8'ha7});
        issue({7'h37, 1'b1, 8'hff});
        issue({7'h37, 1'b0, 8'h7f});
        issue({7'h37, 1'b0, 8'h80});
        // moves: back to back, stalled a cycle, abandoned
        issue({4'hc, 12'h123});
        issue({4'hf, 12'hfed});
        issue({4'hc, 12'h456});
        idle();
        issue({4'hf, 12'h789});
        issue({4'hc, 12'habc});
        issue({8'h0e, 8'h3c});
        issue(16'h0900);
        repeat (60) begin
            k = 8'($urandom);
            case ($urandom_range(0, 5))
                0: issue({8'h0e, k});
                1: issue({8'h01, k});
                2: issue({8'h0d, k});
                3: issue({7'h37, 1'($urandom), k});
                4: begin
                    issue({4'hc, 12'($urandom)});
                    issue({4'hf, 12'($urandom)});
                end
                default: begin
                    issue({4'hc, 12'($urandom)});
                    idle();
                    issue({4'hf, 12'($urandom)});
                end
            endcase
        end
        repeat (8) @(negedge clk);
        reportAndStop();
    end
endmodule : byte_move_multiply_exec_test

bind byte_move_multiply_exec byte_move_multiply_exec_checker chk (.clk(clk), .rst(rst),
    .instrWord(instrWord), .instrValid(instrValid), .memRdData(memRdData), .phase(phase),
    .instrTaken(instrTaken), .moveWaiting(moveWaiting), .statusWrEn(statusWrEn),
    .regs(regs), .mem(mem));
